// ===== hw/cpu_ops_defines.svh
// opcode encodings, cycle counts and reset values for the return/rotate/flag core
// assumes inclusion by bare name from the core's module file
`ifndef CPU_OPS_DEFINES_SVH
`define CPU_OPS_DEFINES_SVH
`define OP_PULL_ST    8'h28
`define OP_IRET       8'h40
`define OP_SRET       8'h60
`define OP_ROTL_ACC   8'h2A
`define OP_ROTL_ZP    8'h26
`define OP_ROTR_ACC   8'h6A
`define OP_ROTR_ZP    8'h66
`define OP_NIB_ZP     8'h82
`define OP_SUB_IMM    8'hE9
`define OP_SUB_ZP     8'hE5
`define OP_C_FORCE    8'h38
`define OP_D_FORCE    8'hF8
`define OP_I_FORCE    8'h78
`define OP_T_FORCE    8'h32
`define OP_BSET_A_LO  5'h0B
`define OP_BSET_Z_LO  5'h0F
`define CYC_PULL      4'h4
`define CYC_IRET      4'h6
`define CYC_SRET      4'h6
`define CYC_ROT_ACC   4'h2
`define CYC_ROT_ZP    4'h5
`define CYC_NIB       4'h8
`define CYC_SUB_IMM   4'h2
`define CYC_SUB_ZP    4'h3
`define CYC_T_EXTRA   4'h3
`define CYC_BSET_A    4'h2
`define CYC_BSET_Z    4'h5
`define CYC_FLAG      4'h2
`define CYC_OTHER     4'h2
`define RESET_PC      16'h0000
`define RESET_S       8'hFF
`define RESET_PS      8'h04
`define STACK_PAGE    8'h01
`define ZERO_PAGE     8'h00
`endif

// ===== hw/cpu_ops_pkg.sv
// types shared by the return/rotate/flag core and its bench
// assumes the defines header is on the include path
package cpu_ops_pkg;
  typedef struct packed {
    logic n;
    logic v;
    logic t;
    logic b;
    logic d;
    logic i;
    logic z;
    logic c;
  } ps_t;
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_req_t;
  typedef struct packed {
    logic        en;
    logic [15:0] pc;
    logic [7:0]  a;
    logic [7:0]  x;
    logic [7:0]  s;
    ps_t         ps;
  } preload_t;
  typedef enum logic [3:0] {
    K_NOP, K_PULL, K_IRET, K_SRET, K_ROTA, K_ROTZ,
    K_NIB, K_SUB, K_BSET_A, K_BSET_Z, K_FLAG
  } kind_t;
endpackage

// ===== hw/cpu_return_rotate_flag_ops.sv
// core executing stack returns, rotates, subtract with borrow, bit and flag sets
// assumes a same-clock memory whose read data is valid in the cycle it is addressed
//
// Overview of operation
// RQ1 - the pull-status opcode bumps the stack pointer then loads status from the stack in 4 cycles.
// RQ2 - rotate left moves bit 7 to carry and carry to bit 0, 2 cycles on A and 5 on zero page.
// RQ3 - rotate right moves bit 0 to carry and carry to bit 7, 2 cycles on A and 5 on zero page.
// RQ4 - the nibble rotate swaps the halves of a zero-page byte in 8 cycles over 2 bytes.
// RQ5 - interrupt return pops status, low and high program counter, pre-incrementing S, in 6 cycles.
// RQ6 - subroutine return pops low then high program counter, pre-incrementing S, in 6 cycles.
// RQ7 - with the X-mode flag clear, subtract with borrow puts A minus operand minus not-carry in A.
// RQ8 - with the X-mode flag set, subtract with borrow updates the byte at X and leaves A alone.
// RQ9 - with the X-mode flag set, subtract with borrow takes three extra cycles.
// RQ10 - bit set forces the opcode-selected bit of A or a zero-page byte to one.
// RQ11 - the carry set opcode forces carry to one in 2 cycles.
// RQ12 - the decimal set opcode forces the decimal flag to one in 2 cycles.
// RQ13 - the interrupt-mask set opcode forces the interrupt disable flag to one in 2 cycles.
// RQ14 - the X-mode set opcode forces the X-mode flag so a later subtract with borrow works on the byte at X.
// RQ15 - rotates update negative, zero and carry, and subtract with borrow also overflow; the nibble rotate leaves every flag unchanged.
`include "cpu_ops_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module cpu_return_rotate_flag_ops
  import cpu_ops_pkg::*;
#(
  parameter logic [15:0] RESET_PC   = `RESET_PC,
  parameter logic [7:0]  STACK_PAGE = `STACK_PAGE
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  MEM_RDATA,
  output var  mem_req_t    MEM_REQ,
  input  wire preload_t    PRELOAD,
  output logic             SYNC,
  output logic [15:0]      PC_OUT,
  output logic [7:0]       A_OUT,
  output logic [7:0]       X_OUT,
  output logic [7:0]       S_OUT,
  output ps_t              PS_OUT
);

  function automatic kind_t kind_of(input logic [7:0] op);
    case (op)
      `OP_PULL_ST: kind_of = K_PULL;
      `OP_IRET: kind_of = K_IRET;
      `OP_SRET: kind_of = K_SRET;
      `OP_ROTL_ACC, `OP_ROTR_ACC: kind_of = K_ROTA;
      `OP_ROTL_ZP, `OP_ROTR_ZP: kind_of = K_ROTZ;
      `OP_NIB_ZP: kind_of = K_NIB;
      `OP_SUB_IMM, `OP_SUB_ZP: kind_of = K_SUB;
      `OP_C_FORCE, `OP_D_FORCE, `OP_I_FORCE, `OP_T_FORCE: kind_of = K_FLAG;
      // unknown opcodes fall through as two-cycle no-ops
      default: begin
        if (op[4:0] == `OP_BSET_A_LO) kind_of = K_BSET_A;
        else if (op[4:0] == `OP_BSET_Z_LO) kind_of = K_BSET_Z;
        else kind_of = K_NOP;
      end
    endcase
  endfunction

  function automatic logic [3:0] cyc_len(input logic [7:0] op, input logic t);
    case (op)
      `OP_PULL_ST: cyc_len = `CYC_PULL; // RQ1
      `OP_IRET: cyc_len = `CYC_IRET; // RQ5
      `OP_SRET: cyc_len = `CYC_SRET; // RQ6
      `OP_ROTL_ACC, `OP_ROTR_ACC: cyc_len = `CYC_ROT_ACC; // RQ2
      `OP_ROTL_ZP, `OP_ROTR_ZP: cyc_len = `CYC_ROT_ZP; // RQ3
      `OP_NIB_ZP: cyc_len = `CYC_NIB; // RQ4
      `OP_SUB_IMM: cyc_len = t ? `CYC_SUB_IMM + `CYC_T_EXTRA : `CYC_SUB_IMM; // RQ9
      `OP_SUB_ZP: cyc_len = t ? `CYC_SUB_ZP + `CYC_T_EXTRA : `CYC_SUB_ZP; // RQ9
      `OP_C_FORCE, `OP_D_FORCE, `OP_I_FORCE, `OP_T_FORCE: cyc_len = `CYC_FLAG;
      default: begin
        if (op[4:0] == `OP_BSET_A_LO) cyc_len = `CYC_BSET_A;
        else if (op[4:0] == `OP_BSET_Z_LO) cyc_len = `CYC_BSET_Z; // RQ10
        else cyc_len = `CYC_OTHER;
      end
    endcase
  endfunction

  // returns {carry out, result}
  function automatic logic [8:0] rot(input logic left, input logic [7:0] v, input logic c);
    if (left) rot = {v[7], v[6:0], c}; // RQ2
    else rot = {v[0], c, v[7:1]}; // RQ3
  endfunction

  // returns {carry out, overflow, result}; binary only
  function automatic logic [9:0] subtract_borrow_op(input logic [7:0] m, input logic [7:0] s, input logic c);
    logic [8:0] d;
    logic       ov;
    d = {1'b0, m} - {1'b0, s} - {8'h00, ~c};
    ov = (m[7] ^ s[7]) & (m[7] ^ d[7]);
    // a borrow shows as a clear carry
    subtract_borrow_op = {~d[8], ov, d[7:0]};
  endfunction

  logic [3:0]  cyc_q;
  logic [3:0]  len_q;
  logic [7:0]  op_q;
  kind_t       kind_q;
  logic        tm_q;
  logic [15:0] pc_q;
  logic [7:0]  a_q;
  logic [7:0]  x_q;
  logic [7:0]  s_q;
  ps_t         ps_q;
  logic [7:0]  zp_q;
  logic [7:0]  tmp_q;
  logic [7:0]  aux_q;
  mem_req_t    req;

  logic        run;
  logic        last;
  logic        two_byte;
  logic [3:0]  sub_k;
  logic        stk_rd;
  logic        zp_rd;
  logic        mx_rd;
  logic        zp_wr;
  logic        mx_wr;
  logic        sub_now;
  logic        rot_left;
  logic [8:0]  rot_r;
  logic [9:0]  sub_r;
  logic [7:0]  bset_r;
  logic [7:0]  zp_data;

  // a held core issues no access and reloads PC, A, X, S and status from the preload on each edge
  assign run = ~PRELOAD.en;
  assign last = cyc_q == len_q - 4'h1;
  assign two_byte = kind_q inside {K_ROTZ, K_NIB, K_SUB, K_BSET_Z};
  assign sub_k = (op_q == `OP_SUB_ZP) ? 4'h2 : 4'h1;
  // each stack read sits one cycle after the pointer bump that addresses it
  assign stk_rd = (kind_q == K_PULL && cyc_q == 4'h3)
               || (kind_q == K_IRET && cyc_q >= 4'h3 && cyc_q <= 4'h5)
               || (kind_q == K_SRET && (cyc_q == 4'h3 || cyc_q == 4'h4));
  assign zp_rd = cyc_q == 4'h2
              && (kind_q inside {K_ROTZ, K_NIB, K_BSET_Z}
                  || (kind_q == K_SUB && op_q == `OP_SUB_ZP));
  // x-mode subtract reads the byte at X after the operand, then writes it back
  assign mx_rd = kind_q == K_SUB && tm_q && cyc_q == sub_k + 4'h1;
  assign mx_wr = kind_q == K_SUB && tm_q && cyc_q == sub_k + 4'h2; // RQ8
  assign zp_wr = (kind_q inside {K_ROTZ, K_BSET_Z} && cyc_q == 4'h4)
              || (kind_q == K_NIB && cyc_q == 4'h7);
  assign sub_now = kind_q == K_SUB && (tm_q ? mx_wr : cyc_q == sub_k);
  assign rot_left = op_q == `OP_ROTL_ACC || op_q == `OP_ROTL_ZP;
  // one rotator serves both the accumulator and the zero-page byte
  assign rot_r = rot(rot_left, (kind_q == K_ROTA) ? a_q : tmp_q, ps_q.c);
  // limitation: decimal mode does not adjust the difference
  // RQ7 RQ8
  assign sub_r = subtract_borrow_op(tm_q ? aux_q : a_q, tm_q ? tmp_q : MEM_RDATA, ps_q.c);
  // RQ10
  assign bset_r = ((kind_q == K_BSET_A) ? a_q : tmp_q) | (8'h01 << op_q[7:5]);
  assign zp_data = (kind_q == K_NIB) ? {tmp_q[3:0], tmp_q[7:4]} // RQ4
                 : (kind_q == K_ROTZ) ? rot_r[7:0] : bset_r;

  // memory requests are combinational so that reads land in the same cycle
  always_comb begin
    req = '0;
    if (run) begin
      if (cyc_q == 4'h0 || (cyc_q == 4'h1 && two_byte)) begin
        req.rd = 1'b1;
        req.addr = pc_q;
      end else if (stk_rd) begin
        req.rd = 1'b1;
        req.addr = {STACK_PAGE, s_q};
      end else if (zp_rd) begin
        req.rd = 1'b1;
        req.addr = {`ZERO_PAGE, zp_q};
      end else if (mx_rd) begin
        req.rd = 1'b1;
        req.addr = {`ZERO_PAGE, x_q};
      end else if (zp_wr) begin
        req.wr = 1'b1;
        req.addr = {`ZERO_PAGE, zp_q};
        req.wdata = zp_data;
      end else if (mx_wr) begin
        req.wr = 1'b1;
        req.addr = {`ZERO_PAGE, x_q};
        req.wdata = sub_r[7:0]; // RQ8
      end
    end
  end
  assign MEM_REQ = req;
  assign SYNC = run && cyc_q == 4'h0;

  // sequencer: every opcode runs a fixed cycle count taken at fetch
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cyc_q <= 4'h0;
      len_q <= `CYC_OTHER;
      op_q <= 8'h00;
      kind_q <= K_NOP;
      tm_q <= 1'b0;
    end else if (!run) begin
      cyc_q <= 4'h0;
    end else if (cyc_q == 4'h0) begin
      op_q <= MEM_RDATA;
      kind_q <= kind_of(MEM_RDATA);
      len_q <= cyc_len(MEM_RDATA, ps_q.t);
      // latching T at fetch keeps the length fixed once an instruction starts
      tm_q <= ps_q.t; // RQ14
      cyc_q <= 4'h1;
    end else if (last) begin
      cyc_q <= 4'h0;
    end else begin
      cyc_q <= cyc_q + 4'h1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pc_q <= RESET_PC;
    end else if (!run) begin
      pc_q <= PRELOAD.pc;
    end else if (cyc_q == 4'h0 || (cyc_q == 4'h1 && two_byte)) begin
      pc_q <= pc_q + 16'h0001;
    // popped bytes go straight into the counter; no increment follows
    end else if ((kind_q == K_IRET && cyc_q == 4'h4) || (kind_q == K_SRET && cyc_q == 4'h3)) begin
      pc_q[7:0] <= MEM_RDATA; // RQ5 RQ6
    end else if ((kind_q == K_IRET && cyc_q == 4'h5) || (kind_q == K_SRET && cyc_q == 4'h4)) begin
      pc_q[15:8] <= MEM_RDATA; // RQ5 RQ6
    end
  end

  // stack pointer is bumped before each pop read
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_q <= `RESET_S;
    end else if (!run) begin
      s_q <= PRELOAD.s;
    end else if ((kind_q inside {K_PULL, K_IRET, K_SRET} && cyc_q == 4'h2)
              || (kind_q == K_IRET && (cyc_q == 4'h3 || cyc_q == 4'h4))
              || (kind_q == K_SRET && cyc_q == 4'h3)) begin
      s_q <= s_q + 8'h01; // RQ1 RQ5 RQ6
    end
  end

  // accumulator writers never meet: each is gated by its own kind, and only one kind runs at a time
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      a_q <= 8'h00;
      x_q <= 8'h00;
    end else if (!run) begin
      a_q <= PRELOAD.a;
      x_q <= PRELOAD.x;
    end else if (kind_q == K_ROTA && cyc_q == 4'h1) begin
      a_q <= rot_r[7:0]; // RQ2 RQ3
    end else if (kind_q == K_BSET_A && cyc_q == 4'h1) begin
      a_q <= bset_r; // RQ10
    end else if (sub_now && !tm_q) begin
      a_q <= sub_r[7:0]; // RQ7
    end
  end

  // operand latches: tmp holds the fetched byte, aux the byte at X
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      zp_q <= 8'h00;
      tmp_q <= 8'h00;
      aux_q <= 8'h00;
    end else if (run) begin
      if (cyc_q == 4'h1 && two_byte) zp_q <= MEM_RDATA;
      if (zp_rd || (kind_q == K_SUB && tm_q && cyc_q == sub_k)) tmp_q <= MEM_RDATA;
      if (mx_rd) aux_q <= MEM_RDATA;
    end
  end

  // status: a pulled byte wins, then flag sets, then rotate and subtract results
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ps_q <= `RESET_PS;
    end else if (!run) begin
      ps_q <= PRELOAD.ps;
    end else if ((kind_q inside {K_PULL, K_IRET}) && cyc_q == 4'h3) begin
      ps_q <= MEM_RDATA; // RQ1 RQ5
    end else if (kind_q == K_FLAG && cyc_q == 4'h1) begin
      if (op_q == `OP_C_FORCE) ps_q.c <= 1'b1; // RQ11
      if (op_q == `OP_D_FORCE) ps_q.d <= 1'b1; // RQ12
      if (op_q == `OP_I_FORCE) ps_q.i <= 1'b1; // RQ13
      if (op_q == `OP_T_FORCE) ps_q.t <= 1'b1; // RQ14
    end else if ((kind_q == K_ROTA && cyc_q == 4'h1) || (kind_q == K_ROTZ && cyc_q == 4'h4)) begin
      ps_q.n <= rot_r[7]; // RQ15
      ps_q.z <= rot_r[7:0] == 8'h00;
      ps_q.c <= rot_r[8];
    end else if (sub_now) begin
      ps_q.n <= sub_r[7]; // RQ15
      ps_q.z <= sub_r[7:0] == 8'h00;
      ps_q.v <= sub_r[8];
      ps_q.c <= sub_r[9];
    end
  end

  // outputs are the registers themselves, so they move only on a clock edge or an asynchronous reset
  assign PC_OUT = pc_q;
  assign A_OUT = a_q;
  assign X_OUT = x_q;
  assign S_OUT = s_q;
  assign PS_OUT = ps_q;

endmodule
`default_nettype wire

// ===== test/cpu_ops_props.sv
// port-level checker for the return/rotate/flag core
// assumes one clock domain and the asynchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module cpu_ops_props
  import cpu_ops_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic [7:0]  MEM_RDATA,
  input wire mem_req_t    MEM_REQ,
  input wire preload_t    PRELOAD,
  input wire logic        SYNC,
  input wire logic [15:0] PC_OUT,
  input wire logic [7:0]  A_OUT,
  input wire logic [7:0]  X_OUT,
  input wire logic [7:0]  S_OUT,
  input wire ps_t         PS_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic go;
  // a held core fetches nothing, so only a live fetch starts a check
  assign go = SYNC && !PRELOAD.en;
  chk_carry_set: assert property (go && MEM_RDATA == 8'h38 |-> ##2 (SYNC && PS_OUT.c))
    else $error("carry not set");
  chk_dec_set: assert property (go && MEM_RDATA == 8'hF8 |-> ##2 (SYNC && PS_OUT.d))
    else $error("decimal not set");
  chk_mask_set: assert property (go && MEM_RDATA == 8'h78 |-> ##2 (SYNC && PS_OUT.i))
    else $error("mask not set");
  chk_xmode_set: assert property (go && MEM_RDATA == 8'h32 |-> ##2 (SYNC && PS_OUT.t))
    else $error("x mode not set");
  chk_pull_status: assert property (go && MEM_RDATA == 8'h28 |-> ##3 (MEM_REQ.rd
    && MEM_REQ.addr == {8'h01, S_OUT} && S_OUT == $past(S_OUT, 3) + 8'h01)
    ##1 (SYNC && PS_OUT == $past(MEM_RDATA)))
    else $error("status pull wrong");
  chk_int_return: assert property (go && MEM_RDATA == 8'h40
    |-> ##6 (SYNC && S_OUT == $past(S_OUT, 6) + 8'h03))
    else $error("interrupt return wrong");
  chk_sub_return: assert property (go && MEM_RDATA == 8'h60
    |-> ##6 (SYNC && S_OUT == $past(S_OUT, 6) + 8'h02))
    else $error("subroutine return wrong");
  chk_rol_acc: assert property (go && MEM_RDATA == 8'h2A |-> ##2 (SYNC
    && A_OUT == {$past(A_OUT[6:0], 2), $past(PS_OUT.c, 2)} && PS_OUT.c == $past(A_OUT[7], 2)))
    else $error("rotate left wrong");
  chk_nib_swap: assert property (go && MEM_RDATA == 8'h82 |-> ##7 (MEM_REQ.wr
    && MEM_REQ.wdata == {$past(MEM_RDATA[3:0], 5), $past(MEM_RDATA[7:4], 5)}) ##1 SYNC)
    else $error("nibble swap wrong");
  chk_sub_plain: assert property (go && MEM_RDATA == 8'hE9 && !PS_OUT.t |-> ##2 (SYNC
    && A_OUT == $past(A_OUT, 2) - $past(MEM_RDATA) - {7'h00, !$past(PS_OUT.c, 2)}))
    else $error("subtract wrong");
  chk_sub_xmode: assert property (go && MEM_RDATA == 8'hE9 && PS_OUT.t |-> ##3 (MEM_REQ.wr
    && MEM_REQ.addr == {8'h00, X_OUT}) ##2 (SYNC && A_OUT == $past(A_OUT, 5)))
    else $error("x mode subtract wrong");
  chk_sub_xzp: assert property (go && MEM_RDATA == 8'hE5 && PS_OUT.t |-> ##4 (MEM_REQ.wr
    && MEM_REQ.addr == {8'h00, X_OUT}) ##2 (SYNC && A_OUT == $past(A_OUT, 6)))
    else $error("x mode zero-page subtract wrong");
  cover property (go && MEM_RDATA == 8'h40);
  cover property (go && MEM_RDATA == 8'h82);
  cover property (go && MEM_RDATA == 8'hE9 && PS_OUT.t);
  cover property (go && MEM_RDATA == 8'hE5 && PS_OUT.t);
endmodule
bind cpu_return_rotate_flag_ops cpu_ops_props u_props (.CLK(CLK), .RST(RST),
  .MEM_RDATA(MEM_RDATA), .MEM_REQ(MEM_REQ), .PRELOAD(PRELOAD), .SYNC(SYNC),
  .PC_OUT(PC_OUT), .A_OUT(A_OUT), .X_OUT(X_OUT), .S_OUT(S_OUT), .PS_OUT(PS_OUT));
`default_nettype wire

// ===== test/cpu_mem_model.sv
// memory holding code, zero page and stack for the core
// assumes one request per cycle and a same-cycle read
`timescale 1ns/1ns
`default_nettype none
module cpu_mem_model
  import cpu_ops_pkg::*;
(
  input  wire logic     clk,
  input  wire mem_req_t req,
  output logic [7:0]    rdata
);
  logic [7:0] mem [0:65535];
  logic       tog_q = 1'b0;
  // an idle read bus wanders so a stale byte never passes for data
  always @(posedge clk) begin
    tog_q <= !tog_q;
    if (req.wr) begin
      mem[req.addr] <= req.wdata;
    end
  end
  assign rdata = req.rd ? mem[req.addr] : {8{tog_q}};
endmodule
`default_nettype wire

// ===== test/cpu_return_rotate_flag_ops_tb_top.sv
// self-checking bench for the return/rotate/flag core
// assumes the memory model stands in for code, zero page and stack
`timescale 1ns/1ns
`default_nettype none
module cpu_return_rotate_flag_ops_tb_top;
  import cpu_ops_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  rdata;
  mem_req_t    req;
  preload_t    pre = {1'b1, 48'h0};
  logic        sync;
  logic [15:0] pc;
  logic [7:0]  a;
  logic [7:0]  x;
  logic [7:0]  s;
  ps_t         ps;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  cpu_return_rotate_flag_ops u_dut (.CLK(clk), .RST(rst), .MEM_RDATA(rdata), .MEM_REQ(req),
    .PRELOAD(pre), .SYNC(sync), .PC_OUT(pc), .A_OUT(a), .X_OUT(x), .S_OUT(s), .PS_OUT(ps));
  cpu_mem_model u_mem (.clk(clk), .req(req), .rdata(rdata));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [15:0] ad, input logic [7:0] b[$]);
    foreach (b[i]) u_mem.mem[ad + 16'(i)] = b[i];
  endtask
  // loads state, lets the core run n cycles, then expects an opcode fetch
  task automatic run(input logic [15:0] p, input logic [7:0] ra, rx, rs, rp, input int n);
    @(posedge clk);
    #1;
    pre = {1'b1, p, ra, rx, rs, rp};
    @(posedge clk);
    #1;
    pre.en = 1'b0;
    repeat (n) @(posedge clk);
    #1;
    chk({15'h0, sync}, 16'h0001);
  endtask
  task automatic t_flags();
    put(16'h0200, '{8'h38, 8'hF8, 8'h78, 8'h32});
    run(16'h0200, 8'h00, 8'h00, 8'hFF, 8'h00, 8);
    chk(ps, 16'h002D);
    chk(pc, 16'h0204);
    $display("test flags done");
  endtask
  task automatic t_returns();
    put(16'h0300, '{8'h28, 8'h60});
    put(16'h01F1, '{8'hC3, 8'h34, 8'h12});
    run(16'h0300, 8'h00, 8'h00, 8'hF0, 8'h00, 10);
    chk(ps, 16'h00C3);
    chk(pc, 16'h1234);
    chk(s, 16'h00F3);
    put(16'h0400, '{8'h40});
    put(16'h01E1, '{8'h81, 8'h78, 8'h56});
    run(16'h0400, 8'h00, 8'h00, 8'hE0, 8'h00, 6);
    chk({ps, s}, 16'h81E3);
    chk(pc, 16'h5678);
    $display("test returns done");
  endtask
  task automatic t_rotates();
    put(16'h0500, '{8'h2A, 8'h6A, 8'h26, 8'h10, 8'h66, 8'h11});
    put(16'h0010, '{8'h80, 8'h01});
    run(16'h0500, 8'h81, 8'h00, 8'hFF, 8'h00, 14);
    chk(a, 16'h0081);
    chk({u_mem.mem[16'h0010], u_mem.mem[16'h0011]}, 16'h0080);
    chk(ps, 16'h0081);
    chk(pc, 16'h0506);
    put(16'h0600, '{8'h82, 8'h20});
    put(16'h0020, '{8'h3C});
    run(16'h0600, 8'h00, 8'h00, 8'hFF, 8'h00, 8);
    chk(u_mem.mem[16'h0020], 16'h00C3);
    $display("test rotates done");
  endtask
  task automatic t_subtract();
    put(16'h0700, '{8'hE9, 8'h10, 8'hE5, 8'h30});
    put(16'h0030, '{8'h90});
    run(16'h0700, 8'h20, 8'h00, 8'hFF, 8'h01, 5);
    chk(a, 16'h0080);
    chk(ps, 16'h00C0);
    put(16'h0800, '{8'hE9, 8'h10});
    put(16'h0040, '{8'h50});
    run(16'h0800, 8'h33, 8'h40, 8'hFF, 8'h21, 5);
    chk(u_mem.mem[16'h0040], 16'h0040);
    chk(a, 16'h0033);
    chk(pc, 16'h0802);
    chk(ps, 16'h0021);
    chk(x, 16'h0040);
    put(16'h0A00, '{8'hE5, 8'h30});
    run(16'h0A00, 8'h33, 8'h40, 8'hFF, 8'h21, 6);
    chk(u_mem.mem[16'h0040], 16'h00B0);
    chk(a, 16'h0033);
    chk(pc, 16'h0A02);
    chk(ps, 16'h00E0);
    $display("test subtract done");
  endtask
  task automatic t_bitset();
    put(16'h0900, '{8'h6B, 8'hEF, 8'h50});
    put(16'h0050, '{8'h00});
    run(16'h0900, 8'h00, 8'h00, 8'hFF, 8'h00, 7);
    chk(a, 16'h0008);
    chk(u_mem.mem[16'h0050], 16'h0080);
    chk(pc, 16'h0903);
    $display("test bitset done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    t_flags();
    t_returns();
    t_rotates();
    t_subtract();
    t_bitset();
    close_out();
  end
endmodule
`default_nettype wire
